// ==== src/ivpu_defs.svh ====
`ifndef IVPU_DEFS_SVH
`define IVPU_DEFS_SVH
`define VEC_AREA_BASE 24'hFFFF00
`define VEC_STEP 8'h04
`define VEC_SWTRAP0 8'h00
`define VEC_ILLEGAL 8'h08
`define VEC_PIN_NMI 8'h20
`define VEC_WATCHDOG 8'h24
`define VEC_MASKABLE_FIRST 8'h28
`define VEC_DMA_DONE_FIRST 8'hA0
`define VEC_RESERVED_FIRST 8'hB0
`define START_CODE_FIRST 8'h28
`define START_CODE_LAST 8'h9C
`define START_CODE_SOFT 8'hFC
`define LEVEL_NMI 3'h7
`define LEVEL_DMA 3'h6
`define MASK_RESET 3'h7
`define NUM_MASKABLE 35
`define NUM_TRIGGERABLE 31
`endif

// ==== src/ivpu_pkg.sv ====
package ivpu_pkg;
    typedef logic [2:0] level_t;
    typedef logic [7:0] vector_t;
    typedef enum logic [1:0]
    {
        KIND_MASKABLE = 2'h0,
        KIND_PIN_NMI = 2'h1,
        KIND_WATCHDOG = 2'h2,
        KIND_DMA = 2'h3
    } req_kind_t;
    // request handed to the cpu core
    typedef struct packed
    {
        logic valid;
        req_kind_t kind;
        level_t level;
        vector_t vector;
        logic [1:0] dmaChannel;
    } cpu_req_t;
    // cpu side events
    typedef struct packed
    {
        logic acceptStrobe;
        logic trapStrobe;
        logic illegalStrobe;
        logic [2:0] trapNumber;
        logic firstInstrDone;
        logic returnStrobe;
        level_t restoredMask;
        logic setMaskStrobe;
        level_t setMaskValue;
    } cpu_evt_t;
endpackage

// ==== src/ivpu_priority_pick.sv ====
`timescale 1ns/100ps
`include "ivpu_defs.svh"
// lowest index (smallest vector) with highest level
module ivpu_priority_pick
#(
    parameter int N = 35
)
(
    // pending inputs
    input wire logic [N-1:0] pending,
    input wire logic [N*3-1:0] levels,
    // winner
    output logic found,
    output logic [5:0] index,
    output logic [2:0] level
);
    import ivpu_pkg::*;

    initial
    begin
        if (N < 1 || N > 63)
        begin
            $error("ivpu_priority_pick: N out of range");
        end
    end

    always_comb
    begin
        found = 1'b0;
        index = 6'h00;
        level = 3'h0;
        for (int i = 0; i < N; i++)
        begin
            // strictly greater keeps smaller vector on ties
            if (pending[i] && levels[i*3 +: 3] != 3'h0 && levels[i*3 +: 3] != 3'h7
                && (!found || levels[i*3 +: 3] > level))
            begin
                found = 1'b1;
                index = 6'(i);
                level = levels[i*3 +: 3];
            end
        end
    end
endmodule

// ==== src/interrupt_vector_priority_unit.sv ====
`timescale 1ns/100ps
`include "ivpu_defs.svh"
// Notes on behaviour
// - traps ignore mask, never change mask
// - trap handler nests requests at mask or above
// - requests at or above mask nest, except maskable levels 0 and 7
// - new request sampled after first instruction
// - vector area FFFF00H to FFFFFFH only
// - nonmaskable vectors 0000H to 0024H step four
// - nine pin requests 0028H to 0048H
// - timer requests 004CH to 0080H
// - serial from 0084H, conversion done 009CH
// - dma done 00A0H to 00ACH, no code
// - start code equals vector low byte
// - code FCH selects software dma request
// - dma requests presented at level six
// - fetch address is base plus vector
// - equal levels: dma first, then smaller vector, cleared
// - maskable accept sets mask level plus one, dma accept leaves it
module interrupt_vector_priority_unit
#(
    parameter int DMA_CHANNELS = 4
)
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // request events, one bit per maskable source in vector order
    input wire logic [`NUM_MASKABLE-1:0] sourceEvent,
    input wire logic [`NUM_MASKABLE*3-1:0] sourceLevel,
    input wire logic pinNmiEvent,
    input wire logic watchdogRequest,
    // dma start codes and software start strobes
    input wire logic [DMA_CHANNELS*8-1:0] dmaStartCode,
    input wire logic [DMA_CHANNELS-1:0] softStartStrobe,
    // cpu events
    input wire ivpu_pkg::cpu_evt_t cpuEvent,
    // to cpu
    output ivpu_pkg::cpu_req_t cpuRequest,
    output logic [23:0] fetchAddress,
    output logic [2:0] cpuMaskLevel,
    output logic sampleBlocked,
    output logic [`NUM_MASKABLE-1:0] pendingFlags,
    output logic pinNmiPending,
    output logic [DMA_CHANNELS-1:0] softPending
);
    import ivpu_pkg::*;

    initial
    begin
        if (DMA_CHANNELS != 4)
        begin
            $error("interrupt_vector_priority_unit: four dma channels only");
        end
    end

    // source index to vector: maskable run starts at 0028H
    function automatic vector_t indexToVector(input logic [5:0] idx);
        indexToVector = 8'(`VEC_MASKABLE_FIRST + {idx, 2'b00});
    endfunction

    // start code to source index, valid only for triggerable codes
    function automatic logic codeValid(input vector_t code);
        // only 28H..9CH on a four step
        codeValid = code >= `START_CODE_FIRST && code <= `START_CODE_LAST
            && code[1:0] == 2'b00;
    endfunction

    function automatic logic [5:0] codeToIndex(input vector_t code);
        vector_t off;
        off = 8'(code - `START_CODE_FIRST);
        codeToIndex = off[7:2];
    endfunction

    // ==========================================================
    // pending flags
    // ==========================================================
    logic [`NUM_MASKABLE-1:0] pending, next_pending;
    logic nmiPend, next_nmiPend;
    logic [DMA_CHANNELS-1:0] softPend, next_softPend;
    cpu_req_t held, next_held;
    logic [`NUM_MASKABLE-1:0] dmaRouted;
    logic dmaFound;
    logic [1:0] dmaChan;
    logic [5:0] dmaIdx;
    logic pickFound;
    logic [5:0] pickIdx;
    level_t pickLevel;
    logic [`NUM_MASKABLE-1:0] pickable;

    always_comb
    begin
        dmaRouted = '0;
        dmaFound = 1'b0;
        dmaChan = 2'h0;
        dmaIdx = 6'h00;
        for (int c = DMA_CHANNELS - 1; c >= 0; c--)
        begin
            if (codeValid(dmaStartCode[c*8 +: 8]))
            begin
                dmaRouted[codeToIndex(dmaStartCode[c*8 +: 8])] = 1'b1;
            end
        end
        // lowest channel wins
        for (int c = DMA_CHANNELS - 1; c >= 0; c--)
        begin
            if (codeValid(dmaStartCode[c*8 +: 8])
                && pending[codeToIndex(dmaStartCode[c*8 +: 8])])
            begin
                dmaFound = 1'b1;
                dmaChan = 2'(c);
                dmaIdx = codeToIndex(dmaStartCode[c*8 +: 8]);
            end
            else if (dmaStartCode[c*8 +: 8] == `START_CODE_SOFT && softPend[c])
            begin
                dmaFound = 1'b1;
                dmaChan = 2'(c);
                dmaIdx = 6'h3F;
            end
        end
        pickable = pending & ~dmaRouted;
    end

    ivpu_priority_pick #(.N(`NUM_MASKABLE)) picker
    (
        .pending(pickable),
        .levels(sourceLevel),
        .found(pickFound),
        .index(pickIdx),
        .level(pickLevel)
    );

    // ==========================================================
    // mask level and request selection
    // ==========================================================
    level_t mask, next_mask;
    logic blocked, next_blocked;
    logic accept;

    assign accept = cpuEvent.acceptStrobe && held.valid;

    always_comb
    begin
        next_pending = pending | sourceEvent;
        next_nmiPend = nmiPend | pinNmiEvent;
        next_softPend = softPend | softStartStrobe;
        next_mask = mask;
        next_blocked = blocked;
        next_held = held;
        if (cpuEvent.setMaskStrobe)
        begin
            next_mask = cpuEvent.setMaskValue;
        end
        if (cpuEvent.returnStrobe)
        begin
            next_mask = cpuEvent.restoredMask;
        end
        // trap acceptance bypasses mask and leaves it alone
        if (cpuEvent.trapStrobe || cpuEvent.illegalStrobe)
        begin
            next_blocked = 1'b1;
        end
        if (accept)
        begin
            // hold off sampling until first instruction ran
            next_blocked = 1'b1;
            // clear the delivered request; a new edge still wins
            if (held.kind == KIND_PIN_NMI)
            begin
                next_nmiPend = pinNmiEvent;
            end
            else if (held.kind == KIND_DMA && dmaIdx == 6'h3F)
            begin
                next_softPend[held.dmaChannel] = softStartStrobe[held.dmaChannel];
            end
            else if (held.kind != KIND_WATCHDOG)
            begin
                next_pending[(held.kind == KIND_DMA) ? dmaIdx
                    : 6'(8'(held.vector - `VEC_MASKABLE_FIRST) >> 2)]
                    = sourceEvent[(held.kind == KIND_DMA) ? dmaIdx
                    : 6'(8'(held.vector - `VEC_MASKABLE_FIRST) >> 2)];
            end
            // mask to level plus one, saturating
            if (held.kind == KIND_PIN_NMI || held.kind == KIND_WATCHDOG)
            begin
                next_mask = `LEVEL_NMI;
            end
            else if (held.kind == KIND_MASKABLE)
            begin
                next_mask = (held.level >= 3'h6) ? 3'h7 : 3'(held.level + 3'h1);
            end
        end
        if (cpuEvent.firstInstrDone)
        begin
            next_blocked = 1'b0;
        end
        // offer anything at or above the mask except maskable levels 0 and 7
        next_held = '0;
        if (!next_blocked && !accept)
        begin
            if (nmiPend)
            begin
                next_held = '{1'b1, KIND_PIN_NMI, `LEVEL_NMI, `VEC_PIN_NMI, 2'h0};
            end
            else if (watchdogRequest)
            begin
                next_held = '{1'b1, KIND_WATCHDOG, `LEVEL_NMI, `VEC_WATCHDOG, 2'h0};
            end
            else if (dmaFound && `LEVEL_DMA >= next_mask)
            begin
                next_held = '{1'b1, KIND_DMA, `LEVEL_DMA,
                    (dmaIdx == 6'h3F) ? `START_CODE_SOFT : indexToVector(dmaIdx), dmaChan};
            end
            else if (pickFound && pickLevel >= next_mask)
            begin
                next_held = '{1'b1, KIND_MASKABLE, pickLevel, indexToVector(pickIdx), 2'h0};
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pending <= '0;
            nmiPend <= 1'b0;
            softPend <= '0;
            mask <= `MASK_RESET;
            blocked <= 1'b0;
            held <= '0;
        end
        else
        begin
            pending <= next_pending;
            nmiPend <= next_nmiPend;
            softPend <= next_softPend;
            mask <= next_mask;
            blocked <= next_blocked;
            held <= next_held;
        end
    end

    // ==========================================================
    // vector fetch address
    // ==========================================================
    logic [23:0] fetch, next_fetch;
    logic [2:0] trapNum;

    always_comb
    begin
        trapNum = cpuEvent.trapNumber;
        next_fetch = fetch;
        // traps at step four, illegal shares trap two
        if (cpuEvent.trapStrobe)
        begin
            next_fetch = `VEC_AREA_BASE | 24'({trapNum, 2'b00});
        end
        else if (cpuEvent.illegalStrobe)
        begin
            next_fetch = `VEC_AREA_BASE | 24'(`VEC_ILLEGAL);
        end
        // base plus vector inside the area; maskable source 34 reaches B0H
        else if (accept && held.kind != KIND_DMA)
        begin
            next_fetch = `VEC_AREA_BASE | 24'(held.vector);
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            fetch <= `VEC_AREA_BASE;
        end
        else
        begin
            fetch <= next_fetch;
        end
    end

    assign cpuRequest = held;
    assign fetchAddress = fetch;
    assign cpuMaskLevel = mask;
    assign sampleBlocked = blocked;
    assign pendingFlags = pending;
    assign pinNmiPending = nmiPend;
    assign softPending = softPend;
endmodule

// ==== testbench/ivpu_sva.sv ====
`timescale 1ns/100ps
module ivpu_sva
import ivpu_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // watched ports
    input wire ivpu_pkg::cpu_evt_t cpuEvent,
    input wire ivpu_pkg::cpu_req_t cpuRequest,
    input wire logic [23:0] fetchAddress,
    input wire logic [2:0] cpuMaskLevel,
    input wire logic sampleBlocked
);
    // ========
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence take_s;
        cpuEvent.acceptStrobe && cpuRequest.valid;
    endsequence
    sequence trap_s;
        cpuEvent.trapStrobe && !cpuEvent.acceptStrobe && !cpuEvent.setMaskStrobe;
    endsequence
    chk_reset_state: assert property (disable iff (1'b0) sys_rst |=>
        cpuMaskLevel == 3'h7 && fetchAddress == 24'hFFFF00 && !cpuRequest.valid)
        else $error("reset state wrong");
    chk_fetch_vector: assert property (take_s ##0 cpuRequest.kind != KIND_DMA |=>
        fetchAddress == {16'hFFFF, $past(cpuRequest.vector)})
        else $error("fetch address not base plus vector");
    chk_mask_raise: assert property (take_s ##0 cpuRequest.kind == KIND_MASKABLE |=>
        cpuMaskLevel == ($past(cpuRequest.level) > 3'h5 ? 3'h7 : $past(cpuRequest.level) + 3'h1))
        else $error("mask not level plus one");
    chk_trap_mask: assert property (trap_s |=> $stable(cpuMaskLevel))
        else $error("trap changed mask");
    chk_trap_vector: assert property (trap_s |=>
        fetchAddress == {16'hFFFF, 3'h0, $past(cpuEvent.trapNumber), 2'h0})
        else $error("trap fetch address wrong");
    chk_dma_level: assert property (cpuRequest.valid && cpuRequest.kind == KIND_DMA |->
        cpuRequest.level == 3'h6)
        else $error("dma request not at level six");
    chk_no_reserved: assert property (cpuRequest.valid && cpuRequest.kind != KIND_DMA |->
        cpuRequest.vector < 8'hB0)
        else $error("reserved vector offered");
    chk_accept_block: assert property (take_s |=> sampleBlocked && !cpuRequest.valid)
        else $error("request offered before first instruction");
endmodule
bind interrupt_vector_priority_unit ivpu_sva u_sva
(
    .clk(clk),
    .sys_rst(sys_rst),
    .cpuEvent(cpuEvent),
    .cpuRequest(cpuRequest),
    .fetchAddress(fetchAddress),
    .cpuMaskLevel(cpuMaskLevel),
    .sampleBlocked(sampleBlocked)
);

// ==== testbench/cpu_core_model.sv ====
`timescale 1ns/100ps
module cpu_core_model
import ivpu_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // bench control
    input wire logic holdFirst,
    input wire ivpu_pkg::cpu_evt_t cmd,
    // unit side
    input wire ivpu_pkg::cpu_req_t cpuRequest,
    output ivpu_pkg::cpu_evt_t cpuEvent
);
    // ========
    // core model
    logic acc;
    logic fid;
    logic pend;
    // first instruction after entry, held back for slow runs
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            acc <= 1'b0;
            fid <= 1'b0;
            pend <= 1'b0;
        end
        else
        begin
            acc <= cpuRequest.valid && !acc;
            fid <= pend && !holdFirst && !fid;
            pend <= acc || cmd.trapStrobe || cmd.illegalStrobe || (pend && !fid);
        end
    end
    always_comb
    begin
        cpuEvent = cmd;
        cpuEvent.acceptStrobe = acc;
        cpuEvent.firstInstrDone = fid;
    end
endmodule

// ==== testbench/interrupt_vector_priority_unit_tb.sv ====
`timescale 1ns/100ps
module interrupt_vector_priority_unit_tb;
    import ivpu_pkg::*;
    // ========
    // bench
    logic clk;
    logic sys_rst;
    logic [34:0] sourceEvent;
    logic [104:0] sourceLevel;
    logic pinNmiEvent;
    logic watchdogRequest;
    logic [31:0] dmaStartCode;
    logic [3:0] softStartStrobe;
    logic holdFirst;
    cpu_evt_t cmd;
    cpu_evt_t ev;
    cpu_evt_t cpuEvent;
    cpu_req_t cpuRequest;
    logic [23:0] fetchAddress;
    logic [2:0] cpuMaskLevel;
    logic sampleBlocked;
    logic [34:0] pendingFlags;
    logic pinNmiPending;
    logic [3:0] softPending;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    interrupt_vector_priority_unit u_dut
    (
        .clk(clk), .sys_rst(sys_rst), .sourceEvent(sourceEvent),
        .sourceLevel(sourceLevel), .pinNmiEvent(pinNmiEvent),
        .watchdogRequest(watchdogRequest), .dmaStartCode(dmaStartCode),
        .softStartStrobe(softStartStrobe), .cpuEvent(cpuEvent),
        .cpuRequest(cpuRequest), .fetchAddress(fetchAddress),
        .cpuMaskLevel(cpuMaskLevel), .sampleBlocked(sampleBlocked),
        .pendingFlags(pendingFlags), .pinNmiPending(pinNmiPending),
        .softPending(softPending)
    );
    cpu_core_model u_cpu
    (
        .clk(clk), .sys_rst(sys_rst), .holdFirst(holdFirst), .cmd(cmd),
        .cpuRequest(cpuRequest), .cpuEvent(cpuEvent)
    );
    task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic fire(input int i);
        sourceEvent[i] = 1'b1;
        tick(1);
        sourceEvent = '0;
        tick(1);
    endtask
    task automatic pulse;
        cmd = ev;
        tick(1);
        cmd = '0;
        tick(1);
        ev = '0;
    endtask
    task automatic mask(input logic [2:0] v);
        ev.setMaskStrobe = 1'b1;
        ev.setMaskValue = v;
        pulse();
    endtask
    task automatic ret(input logic [2:0] v);
        ev.returnStrobe = 1'b1;
        ev.restoredMask = v;
        pulse();
    endtask
    // waits for an offer, judges it, lets the core take it
    task automatic want(input logic [1:0] k, input logic [2:0] l, input logic [7:0] v,
        input logic [1:0] c);
        int n;
        n = 0;
        while (cpuRequest.valid !== 1'b1 && n < 40)
        begin
            tick(1);
            n++;
        end
        cmp(cpuRequest.valid, 1'b1);
        cmp(cpuRequest.kind, k);
        cmp(cpuRequest.level, l);
        if (k == KIND_DMA)
            cmp(cpuRequest.dmaChannel, c);
        else
            cmp(cpuRequest.vector, v);
        tick(2);
    endtask
    task automatic t_vectors;
        cmp(cpuMaskLevel, 3'h7);
        cmp(fetchAddress, 24'hFFFF00);
        mask(3'h0);
        for (int i = 0; i < 34; i++)
        begin
            fire(i);
            want(KIND_MASKABLE, 3'h3, 8'h28 + 8'(4 * i), 2'h0);
            cmp(fetchAddress, 24'hFFFF28 + 24'(4 * i));
            cmp(cpuMaskLevel, 3'h4);
            cmp(pendingFlags[i], 1'b0);
            ret(3'h0);
        end
        $display("test vectors done");
    endtask
    task automatic t_order;
        sourceLevel[8:6] = 3'h6;
        sourceEvent[3:1] = 3'h7;
        tick(1);
        sourceEvent = '0;
        want(KIND_MASKABLE, 3'h6, 8'h30, 2'h0);
        cmp(cpuMaskLevel, 3'h7);
        ret(3'h0);
        want(KIND_MASKABLE, 3'h3, 8'h2C, 2'h0);
        ret(3'h0);
        want(KIND_MASKABLE, 3'h3, 8'h34, 2'h0);
        ret(3'h0);
        $display("test order done");
    endtask
    task automatic t_nest;
        holdFirst = 1'b1;
        sourceLevel[14:12] = 3'h2;
        fire(4);
        want(KIND_MASKABLE, 3'h2, 8'h38, 2'h0);
        fire(5);
        repeat (4)
        begin
            cmp(cpuRequest.valid, 1'b0);
            tick(1);
        end
        holdFirst = 1'b0;
        want(KIND_MASKABLE, 3'h3, 8'h3C, 2'h0);
        fire(6);
        tick(4);
        cmp(cpuRequest.valid, 1'b0);
        cmp(pendingFlags[6], 1'b1);
        ret(3'h3);
        want(KIND_MASKABLE, 3'h3, 8'h40, 2'h0);
        ret(3'h0);
        $display("test nest done");
    endtask
    task automatic t_trap;
        mask(3'h7);
        ev.trapStrobe = 1'b1;
        ev.trapNumber = 3'h5;
        pulse();
        cmp(fetchAddress, 24'hFFFF14);
        cmp(cpuMaskLevel, 3'h7);
        ev.illegalStrobe = 1'b1;
        pulse();
        cmp(fetchAddress, 24'hFFFF08);
        cmp(cpuMaskLevel, 3'h7);
        mask(3'h4);
        ev.trapStrobe = 1'b1;
        pulse();
        sourceLevel[23:21] = 3'h4;
        fire(7);
        want(KIND_MASKABLE, 3'h4, 8'h44, 2'h0);
        ret(3'h7);
        pinNmiEvent = 1'b1;
        tick(1);
        pinNmiEvent = 1'b0;
        want(KIND_PIN_NMI, 3'h7, 8'h20, 2'h0);
        cmp(cpuMaskLevel, 3'h7);
        watchdogRequest = 1'b1;
        want(KIND_WATCHDOG, 3'h7, 8'h24, 2'h0);
        watchdogRequest = 1'b0;
        $display("test trap done");
    endtask
    task automatic t_dma;
        mask(3'h0);
        dmaStartCode[15:8] = 8'h3C;
        sourceLevel[17:15] = 3'h1;
        fire(5);
        want(KIND_DMA, 3'h6, 8'h00, 2'h1);
        cmp(cpuMaskLevel, 3'h0);
        dmaStartCode[23:16] = 8'hFC;
        softStartStrobe[2] = 1'b1;
        tick(1);
        softStartStrobe = '0;
        want(KIND_DMA, 3'h6, 8'h00, 2'h2);
        $display("test dma done");
    endtask
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // hang guard, well above the few hundred cycles needed
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            results();
        end
    end
    initial
    begin
        sys_rst = 1'b1;
        sourceEvent = '0;
        sourceLevel = {35{3'h3}};
        pinNmiEvent = 1'b0;
        watchdogRequest = 1'b0;
        dmaStartCode = '0;
        softStartStrobe = '0;
        holdFirst = 1'b0;
        cmd = '0;
        ev = '0;
        tick(6);
        sys_rst = 1'b0;
        tick(1);
        t_vectors();
        t_order();
        t_nest();
        t_trap();
        t_dma();
        results();
    end
endmodule
